// ==== srl_pkg.sv ====
// Constants and state encodings for the serial EEPROM register loader
package srl_pkg;

    // Core clock and serial timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SK_HALF_NS = 800;
    localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_LOW_NS = 250;
    localparam int CS_LOW_CYC = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SK_HALF_LAST = 4'(SK_HALF_CYC - 1);
    localparam logic [3:0] CS_LOW_LAST = 4'(CS_LOW_CYC - 1);

    // Strap capture waits for the pin synchroniser to settle
    localparam logic [2:0] STRAP_WAIT_LAST = 3'h4;

    // Serial frame layout
    localparam int WORD_W = 16;
    localparam int EE_ADDR_W = 8;
    localparam int FRAME_W = 11;
    localparam logic [2:0] OPC_READ = 3'h6;
    localparam logic [4:0] HDR_BITS_WIDE = 5'h0b;
    localparam logic [4:0] HDR_BITS_NARROW = 5'h09;
    localparam logic [4:0] DATA_BITS = 5'h10;
    localparam logic [7:0] LAST_ADDR_WIDE = 8'hff;
    localparam logic [7:0] LAST_ADDR_NARROW = 8'h3f;

    // Command word fields
    localparam int CMD_BANK_BIT = 15;
    localparam int CMD_GLB_MSB = 14;
    localparam int CMD_VEC_MSB = 10;
    localparam int CMD_PHY_VEC_MSB = 9;
    localparam int CMD_VEC_LSB = 5;
    localparam int CMD_REG_MSB = 4;
    localparam int NUM_PORTS = 6;
    localparam logic [15:0] CMD_END = 16'hffff;

    // Management device addresses
    localparam logic [4:0] DEV_PHY_BASE = 5'h00;
    localparam logic [4:0] DEV_SW_BASE = 5'h08;
    localparam logic [4:0] DEV_GLOBAL = 5'h0f;

    // Loader sequence states
    typedef enum logic [5:0] {
        ST_STRAP = 6'h01,
        ST_CMD = 6'h02,
        ST_DATA = 6'h04,
        ST_WRITE = 6'h08,
        ST_HALT = 6'h10,
        ST_OFF = 6'h20
    } srl_state_type;

    // Serial read engine states
    typedef enum logic [3:0] {
        RD_IDLE = 4'h1,
        RD_LOW = 4'h2,
        RD_HIGH = 4'h4,
        RD_GAP = 4'h8
    } srl_rd_state_type;

endpackage

// ==== srl_sync2.sv ====
// Two-stage synchroniser for pins arriving from outside the core clock
`timescale 1ns/1ps
`default_nettype none
module srl_sync2 #(
    parameter int W = 3
) (
    input wire logic clk_i,  // Core clock
    input wire logic nrst_i,  // Async reset, active low
    input wire logic [W-1:0] d_i,  // Raw pin levels
    output logic [W-1:0] q_o  // Synchronised levels
);
    logic [W-1:0] meta_reg;  // First stage, read only by the second

    // Both stages clear to zero; consumers wait before trusting them
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== srl_ee_reader.sv ====
// Three-wire serial EEPROM single-word read engine
`timescale 1ns/1ps
`default_nettype none
module srl_ee_reader
    import srl_pkg::*;
(
    input wire logic clk_i,  // Core clock
    input wire logic nrst_i,  // Async reset, active low
    input wire logic start_i,  // Pulse: begin a read
    input wire logic [7:0] addr_i,  // Word address
    input wire logic wide_i,  // 1: 8 address bits, 0: 6
    input wire logic do_i,  // Synchronised serial data from EEPROM
    output logic done_o,  // Pulse: word ready
    output logic [15:0] data_o,  // Word read
    output logic cs_o,  // Chip select
    output logic sk_o,  // Serial clock
    output logic di_o  // Serial data to EEPROM
);
    import srl_pkg::*;

    typedef struct packed {
        srl_rd_state_type st;
        logic [3:0] tmr;
        logic [4:0] bitn;
        logic [4:0] hdr;
        logic [FRAME_W-1:0] sh_out;
        logic [WORD_W-1:0] sh_in;
        logic cs;
        logic sk;
        logic di;
        logic done;
    } srl_rd_type;

    srl_rd_type r_reg;  // Registered state
    srl_rd_type r_next;  // Next state

    // Clock is made here from the core clock; one pulse per bit, low half first
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        case (r_reg.st)
            RD_IDLE: begin
                if (start_i) begin
                    // Start bit, read opcode, then address MSB first
                    r_next.sh_out = wide_i ? {OPC_READ, addr_i} : {OPC_READ, addr_i[5:0], 2'h0};
                    r_next.hdr = wide_i ? HDR_BITS_WIDE : HDR_BITS_NARROW;
                    r_next.di = 1'b1;
                    r_next.cs = 1'b1;
                    r_next.sk = 1'b0;
                    r_next.bitn = '0;
                    r_next.tmr = '0;
                    r_next.st = RD_LOW;
                end
            end
            RD_LOW: begin
                r_next.tmr = 4'(r_reg.tmr + 4'h1);
                if (r_reg.tmr == SK_HALF_LAST) begin
                    r_next.tmr = '0;
                    r_next.sk = 1'b1;
                    r_next.st = RD_HIGH;
                end
            end
            RD_HIGH: begin
                r_next.tmr = 4'(r_reg.tmr + 4'h1);
                if (r_reg.tmr == SK_HALF_LAST) begin
                    r_next.tmr = '0;
                    r_next.sk = 1'b0;
                    // Past the header, each rising edge presents the next data bit
                    if (r_reg.bitn >= r_reg.hdr) begin
                        r_next.sh_in = {r_reg.sh_in[WORD_W-2:0], do_i};
                    end
                    r_next.sh_out = {r_reg.sh_out[FRAME_W-2:0], 1'b0};
                    r_next.di = r_reg.sh_out[FRAME_W-2];
                    r_next.bitn = 5'(r_reg.bitn + 5'h01);
                    if (r_reg.bitn == 5'(r_reg.hdr + DATA_BITS - 5'h01)) begin
                        r_next.cs = 1'b0;
                        r_next.di = 1'b0;
                        r_next.st = RD_GAP;
                    end else begin
                        r_next.st = RD_LOW;
                    end
                end
            end
            RD_GAP: begin
                // Chip select must stay low a minimum time between reads
                r_next.tmr = 4'(r_reg.tmr + 4'h1);
                if (r_reg.tmr == CS_LOW_LAST) begin
                    r_next.tmr = '0;
                    r_next.done = 1'b1;
                    r_next.st = RD_IDLE;
                end
            end
            default: begin
                r_next.st = RD_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_reg <= '{st: RD_IDLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign done_o = r_reg.done;
    assign data_o = r_reg.sh_in;
    assign cs_o = r_reg.cs;
    assign sk_o = r_reg.sk;
    assign di_o = r_reg.di;
endmodule
`default_nettype wire

// ==== srl_loader_top.sv ====
// Top of the serial EEPROM register loader: walks the command list and issues writes
`timescale 1ns/1ps
`default_nettype none
module srl_loader_top (
    input wire logic CLOCK_I,  // Core clock, 10 MHz
    input wire logic NRST_I,  // Hardware reset, async, active low
    input wire logic STANDALONE_MODE_I,  // Pin: standalone switch mode selected
    input wire logic EEPROM_SIZE_STRAP_PIN_I,  // Pin: high selects the smallest part
    input wire logic EE_DO_I,  // Serial data from EEPROM
    output logic EE_CS_O,  // EEPROM chip select
    output logic EE_SK_O,  // EEPROM serial clock
    output logic EE_DI_O,  // Serial data to EEPROM
    output logic MGMT_WR_REQ_O,  // Management write request, held to ack
    output logic [4:0] MGMT_DEV_O,  // Management device address
    output logic [4:0] MGMT_REG_O,  // Management register address
    output logic [15:0] MGMT_DATA_O,  // Management write data
    input wire logic MGMT_WR_ACK_I,  // Management write accepted
    output logic CONFIG_LOAD_DONE_FLAG_O,  // Load complete, sticky
    output logic LOADER_BUSY_O  // Loader walking the list
);
    import srl_pkg::*;

    // Whole loader state in one record
    typedef struct packed {
        srl_state_type st;
        logic [2:0] wait_cnt;
        logic wide;
        logic [EE_ADDR_W-1:0] addr;
        logic [WORD_W-1:0] cmd;
        logic [WORD_W-1:0] payload_word;
        logic [NUM_PORTS-1:0] pend;
        logic glob;
        logic start;
        logic wr_req;
        logic [4:0] dev;
        logic [4:0] regn;
        logic [WORD_W-1:0] data;
        logic config_load_done_flag;
        logic busy;
    } srl_top_type;

    srl_top_type s_reg;  // Registered state
    srl_top_type s_next;  // Next state

    logic [2:0] pins_s;  // Synchronised pin levels
    logic standalone_s;  // Standalone mode, synchronised
    logic strap_s;  // Size strap, synchronised
    logic do_s;  // Serial data, synchronised
    logic rd_done;  // Reader finished a word
    logic [15:0] rd_data;  // Word from the reader
    logic [7:0] last_addr;  // Highest word of the strapped part
    logic [2:0] sel_idx;  // Lowest pending port
    logic glob_hit;  // Command targets the global set
    logic [NUM_PORTS-1:0] vec;  // Port vector of the fetched command

    // Mode, strap and serial data pins pass two flops before use
    srl_sync2 #(
        .W(3)
    ) srl_sync2_inst (
        .clk_i(CLOCK_I),
        .nrst_i(NRST_I),
        .d_i({STANDALONE_MODE_I, EEPROM_SIZE_STRAP_PIN_I, EE_DO_I}),
        .q_o(pins_s)
    );

    assign standalone_s = pins_s[2];
    assign strap_s = pins_s[1];
    assign do_s = pins_s[0];

    // Serial read engine; one full transaction per word keeps it simple
    srl_ee_reader srl_ee_reader_inst (
        .clk_i(CLOCK_I),
        .nrst_i(NRST_I),
        .start_i(s_reg.start),
        .addr_i(s_reg.addr),
        .wide_i(s_reg.wide),
        .do_i(do_s),
        .done_o(rd_done),
        .data_o(rd_data),
        .cs_o(EE_CS_O),
        .sk_o(EE_SK_O),
        .di_o(EE_DI_O)
    );

    // Address ceiling follows the strapped size
    assign last_addr = s_reg.wide ? LAST_ADDR_WIDE : LAST_ADDR_NARROW;

    // Global target: bank zero and the full 14:5 field set
    assign glob_hit = ~s_reg.cmd[CMD_BANK_BIT] & (&s_reg.cmd[CMD_GLB_MSB:CMD_VEC_LSB]);

    // Port vector; bank zero only has PHYs for the lower five ports
    always_comb begin
        vec = s_reg.cmd[CMD_VEC_MSB:CMD_VEC_LSB];
        if (!s_reg.cmd[CMD_BANK_BIT]) begin
            vec = {1'b0, s_reg.cmd[CMD_PHY_VEC_MSB:CMD_VEC_LSB]};
        end
    end

    // Lowest set pending bit goes first, so ports are written in ascending order
    always_comb begin
        sel_idx = '0;
        for (int i = NUM_PORTS - 1; i >= 0; i--) begin
            if (s_reg.pend[i]) begin
                sel_idx = 3'(i);
            end
        end
    end

    // Sequence: strap capture, command fetch, payload fetch, writes, repeat
    always_comb begin
        s_next = s_reg;
        s_next.start = 1'b0;
        case (s_reg.st)
            ST_STRAP: begin
                // Wait until the synchronisers hold real pin levels, then decide once
                s_next.wait_cnt = 3'(s_reg.wait_cnt + 3'h1);
                if (s_reg.wait_cnt == STRAP_WAIT_LAST) begin
                    s_next.wide = ~strap_s;
                    if (standalone_s) begin
                        s_next.st = ST_OFF;
                    end else begin
                        s_next.addr = '0;
                        s_next.start = 1'b1;
                        s_next.busy = 1'b1;
                        s_next.st = ST_CMD;
                    end
                end
            end
            ST_CMD: begin
                // Word just read sits at an even address and is a command
                if (rd_done) begin
                    if (rd_data == CMD_END) begin
                        // Terminator: no further fetch, no further write
                        s_next.config_load_done_flag = 1'b1;
                        s_next.busy = 1'b0;
                        s_next.st = ST_HALT;
                    end else if (s_reg.addr == last_addr) begin
                        // Image ran off the end without a terminator; stop cleanly
                        s_next.config_load_done_flag = 1'b1;
                        s_next.busy = 1'b0;
                        s_next.st = ST_HALT;
                    end else begin
                        s_next.cmd = rd_data;
                        s_next.addr = 8'(s_reg.addr + 8'h01);
                        s_next.start = 1'b1;
                        s_next.st = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                // Odd word is the payload for the command just fetched
                if (rd_done) begin
                    s_next.payload_word = rd_data;
                    s_next.glob = glob_hit;
                    s_next.pend = glob_hit ? '0 : vec;
                    s_next.st = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (s_reg.wr_req) begin
                    // Hold the request until the register space takes it
                    if (MGMT_WR_ACK_I) begin
                        s_next.wr_req = 1'b0;
                    end
                end else if (s_reg.glob) begin
                    s_next.dev = DEV_GLOBAL;
                    s_next.regn = s_reg.cmd[CMD_REG_MSB:0];
                    s_next.data = s_reg.payload_word;
                    s_next.glob = 1'b0;
                    s_next.wr_req = 1'b1;
                end else if (|s_reg.pend) begin
                    // One write per selected port, same payload each time
                    if (s_reg.cmd[CMD_BANK_BIT]) begin
                        s_next.dev = 5'(DEV_SW_BASE + {2'h0, sel_idx});
                    end else begin
                        s_next.dev = 5'(DEV_PHY_BASE + {2'h0, sel_idx});
                    end
                    s_next.regn = s_reg.cmd[CMD_REG_MSB:0];
                    s_next.data = s_reg.payload_word;
                    s_next.pend[sel_idx] = 1'b0;
                    s_next.wr_req = 1'b1;
                end else if (s_reg.addr == last_addr) begin
                    // No room left for another command; treat as the end of list
                    s_next.config_load_done_flag = 1'b1;
                    s_next.busy = 1'b0;
                    s_next.st = ST_HALT;
                end else begin
                    // All writes acknowledged before the next fetch starts
                    s_next.addr = 8'(s_reg.addr + 8'h01);
                    s_next.start = 1'b1;
                    s_next.st = ST_CMD;
                end
            end
            ST_HALT: begin
                // Done for good; only a hardware reset runs the list again
                s_next.busy = 1'b0;
            end
            ST_OFF: begin
                // Standalone mode: EEPROM is never touched
                s_next.busy = 1'b0;
            end
            default: begin
                s_next.st = ST_HALT;
            end
        endcase
    end

    // State register; reset takes constants only, straps are caught after release
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s_reg <= '{st: ST_STRAP, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs come straight from the state register
    assign MGMT_WR_REQ_O = s_reg.wr_req;
    assign MGMT_DEV_O = s_reg.dev;
    assign MGMT_REG_O = s_reg.regn;
    assign MGMT_DATA_O = s_reg.data;
    assign CONFIG_LOAD_DONE_FLAG_O = s_reg.config_load_done_flag;
    assign LOADER_BUSY_O = s_reg.busy;

endmodule
`default_nettype wire

// ==== srl_asserts.sv ====
// Port-level checker for the serial EEPROM register loader
`timescale 1ns/1ps
`default_nettype none
module srl_loader_checker (
    input wire logic CLOCK_I,  // Core clock
    input wire logic NRST_I,  // Reset, active low
    input wire logic EE_CS_O,  // Chip select
    input wire logic EE_SK_O,  // Serial clock
    input wire logic EE_DI_O,  // Serial data to EEPROM
    input wire logic MGMT_WR_REQ_O,  // Write request
    input wire logic [4:0] MGMT_DEV_O,  // Device address
    input wire logic [4:0] MGMT_REG_O,  // Register address
    input wire logic [15:0] MGMT_DATA_O,  // Write data
    input wire logic MGMT_WR_ACK_I,  // Write accept
    input wire logic CONFIG_LOAD_DONE_FLAG_O,  // Load complete
    input wire logic LOADER_BUSY_O  // Loader busy
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);

    // Request waiting, with no accept in this or the previous cycle
    sequence s_wait;
        MGMT_WR_REQ_O && !MGMT_WR_ACK_I && !$past(MGMT_WR_ACK_I);
    endsequence
    // Request taken by the register side
    sequence s_taken;
        MGMT_WR_REQ_O && MGMT_WR_ACK_I;
    endsequence

    property p_req_hold;
        s_wait |=> MGMT_WR_REQ_O && $stable(MGMT_DEV_O) && $stable(MGMT_REG_O)
            && $stable(MGMT_DATA_O);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("write request changed early");

    property p_req_drop;
        s_taken |-> ##[1:2] !MGMT_WR_REQ_O;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("write request not released");

    property p_no_overlap;
        EE_CS_O |-> !MGMT_WR_REQ_O;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("write during word fetch");

    property p_done_sticky;
        CONFIG_LOAD_DONE_FLAG_O |=> CONFIG_LOAD_DONE_FLAG_O;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag cleared");

    property p_done_quiet;
        CONFIG_LOAD_DONE_FLAG_O |-> !LOADER_BUSY_O && !EE_CS_O && !MGMT_WR_REQ_O;
    endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("activity after done");

    property p_done_rise;
        $rose(CONFIG_LOAD_DONE_FLAG_O) |-> $fell(LOADER_BUSY_O);
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("busy not ended with done");

    property p_frame_start;
        $rose(EE_CS_O) |-> EE_DI_O && !EE_SK_O;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame lacks start bit");

    property p_sk_high;
        $rose(EE_SK_O) |-> EE_SK_O [*8] ##1 !EE_SK_O;
    endproperty
    a_sk_high: assert property (p_sk_high) else $error("serial clock high half wrong");

    property p_cs_gap;
        $fell(EE_CS_O) |-> !EE_CS_O [*3];
    endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("chip select gap too short");

    // Only PHY, switch port and global devices may be addressed
    property p_dev_legal;
        MGMT_WR_REQ_O |-> MGMT_DEV_O <= 5'h04 || MGMT_DEV_O == 5'h0f
            || (MGMT_DEV_O >= 5'h08 && MGMT_DEV_O <= 5'h0d);
    endproperty
    a_dev_legal: assert property (p_dev_legal) else $error("illegal device address");
endmodule
`default_nettype wire

// ==== srl_eeprom_model.sv ====
// Behavioural x16 serial EEPROM answering three-wire read frames
`timescale 1ns/1ps
`default_nettype none
module srl_eeprom_model (
    input wire logic cs_i,  // Chip select from loader
    input wire logic sk_i,  // Serial clock from loader
    input wire logic di_i,  // Serial data from loader
    input wire logic wide_i,  // 1: 8 address bits, 0: 6
    output logic do_o  // Serial data to loader
);
    logic [15:0] mem [0:255];  // One 16-bit word per address
    logic [8:0] rd_addr[$];  // Read log: bad-opcode flag and address
    logic [10:0] hdr;  // Header shift register
    logic [7:0] addr;  // Decoded word address
    int cnt;  // Rising clock edges in this frame
    int hl;  // Header length in bits

    initial begin
        do_o = 1'b1;
        cnt = 0;
    end

    // Header in on rising clock, then data MSB first; header length follows the strap
    always @(posedge sk_i) begin
        hl = wide_i ? 11 : 9;
        if (cs_i) begin
            cnt = cnt + 1;
            if (cnt <= hl) hdr = {hdr[9:0], di_i};
            if (cnt == hl) begin
                addr = wide_i ? hdr[7:0] : {2'h0, hdr[5:0]};
                rd_addr.push_back({(wide_i ? hdr[10:8] : hdr[8:6]) != 3'h6, addr});
                do_o = 1'b0;  // Dummy zero before data
            end else if (cnt > hl && cnt <= hl + 16) begin
                do_o = mem[addr][15 - (cnt - hl - 1)];
            end
        end
    end

    // Deselected line floats with no pull, so show the inverse of the last bit
    always @(negedge cs_i) begin
        cnt = 0;
        do_o = ~do_o;
    end
endmodule
`default_nettype wire

// ==== tb_serial_eeprom_register_loader.sv ====
// Self-checking testbench for the serial EEPROM register loader
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_register_loader;
    import srl_pkg::*;
    logic CLOCK_I, NRST_I, STANDALONE_MODE_I, EEPROM_SIZE_STRAP_PIN_I, EE_DO_I;
    logic EE_CS_O, EE_SK_O, EE_DI_O, MGMT_WR_REQ_O, MGMT_WR_ACK_I;
    logic CONFIG_LOAD_DONE_FLAG_O, LOADER_BUSY_O;
    logic [4:0] MGMT_DEV_O, MGMT_REG_O;  // Write target
    logic [15:0] MGMT_DATA_O;  // Write data
    logic [25:0] wr_q[$];  // Accepted writes as {dev, reg, data}
    int mismatches, cmp_count, ack_delay, ack_cnt;
    logic ack_wait;  // Accept given, waiting for request to drop

    srl_loader_top srl_loader_top_inst (.CLOCK_I(CLOCK_I), .NRST_I(NRST_I),
        .STANDALONE_MODE_I(STANDALONE_MODE_I), .EEPROM_SIZE_STRAP_PIN_I(EEPROM_SIZE_STRAP_PIN_I),
        .EE_DO_I(EE_DO_I), .EE_CS_O(EE_CS_O), .EE_SK_O(EE_SK_O), .EE_DI_O(EE_DI_O),
        .MGMT_WR_REQ_O(MGMT_WR_REQ_O), .MGMT_DEV_O(MGMT_DEV_O), .MGMT_REG_O(MGMT_REG_O),
        .MGMT_DATA_O(MGMT_DATA_O), .MGMT_WR_ACK_I(MGMT_WR_ACK_I),
        .CONFIG_LOAD_DONE_FLAG_O(CONFIG_LOAD_DONE_FLAG_O), .LOADER_BUSY_O(LOADER_BUSY_O));

    srl_eeprom_model srl_eeprom_model_inst (.cs_i(EE_CS_O), .sk_i(EE_SK_O), .di_i(EE_DI_O),
        .wide_i(!EEPROM_SIZE_STRAP_PIN_I), .do_o(EE_DO_I));

    // Core clock, 100 ns period
    initial begin
        CLOCK_I = 1'b0;
        forever #50 CLOCK_I = ~CLOCK_I;
    end

    // Register side: one-cycle accept after ack_delay cycles, logs each write
    always @(negedge CLOCK_I) begin
        if (!NRST_I) begin
            MGMT_WR_ACK_I <= 1'b0;
            ack_wait <= 1'b0;
            ack_cnt <= 0;
        end else if (MGMT_WR_ACK_I) begin
            MGMT_WR_ACK_I <= 1'b0;
            wr_q.push_back({MGMT_DEV_O, MGMT_REG_O, MGMT_DATA_O});
            // The request drops on the accept edge; one still up here is not accepted twice
            ack_wait <= MGMT_WR_REQ_O;
            ack_cnt <= 0;
        end else if (ack_wait) begin
            if (!MGMT_WR_REQ_O) ack_wait <= 1'b0;
            ack_cnt <= 0;
        end else if (MGMT_WR_REQ_O) begin
            if (ack_cnt >= ack_delay) MGMT_WR_ACK_I <= 1'b1;
            else ack_cnt <= ack_cnt + 1;
        end
    end

    task automatic check(input logic [25:0] got, input logic [25:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Straps are set while reset is held, so they are stable at capture
    task automatic do_reset(input logic strap, input logic alone);
        @(negedge CLOCK_I);
        NRST_I = 1'b0;
        EEPROM_SIZE_STRAP_PIN_I = strap;
        STANDALONE_MODE_I = alone;
        wr_q.delete();
        srl_eeprom_model_inst.rd_addr.delete();
        repeat (20) @(negedge CLOCK_I);
        NRST_I = 1'b1;
    endtask

    // Bounded wait for done, then a quiet spell to catch stray reads or writes
    task automatic wait_done();
        logic seen_busy = 1'b0;  // Busy must show while the list is walked
        for (int i = 0; i < 40000 && CONFIG_LOAD_DONE_FLAG_O !== 1'b1; i++) begin
            @(negedge CLOCK_I);
            if (LOADER_BUSY_O === 1'b1) seen_busy = 1'b1;
        end
        check(26'(CONFIG_LOAD_DONE_FLAG_O), 26'h1);
        check(26'({seen_busy, LOADER_BUSY_O}), 26'h2);
        if (CONFIG_LOAD_DONE_FLAG_O !== 1'b1) give_verdict();
        repeat (1000) @(negedge CLOCK_I);
    endtask

    // Compare the read log with addresses 0 upward, all with the read opcode
    task automatic check_reads(input int n);
        check(26'(srl_eeprom_model_inst.rd_addr.size()), 26'(n));
        for (int i = 0; i < n; i++) check(26'(srl_eeprom_model_inst.rd_addr[i]), 26'(i));
    endtask

    // Wide part: multi-port switch, PHY subset and global writes, then stop
    task automatic test_full_list();
        ack_delay = 0;
        srl_eeprom_model_inst.mem[0] = 16'h87e5;  // Switch ports 0-5, register 5
        srl_eeprom_model_inst.mem[1] = 16'ha5c3;
        srl_eeprom_model_inst.mem[2] = 16'h02b0;  // PHY 0, 2, 4, register 0x10
        srl_eeprom_model_inst.mem[3] = 16'h0f1e;
        srl_eeprom_model_inst.mem[4] = 16'h7fe2;  // Global set, register 2
        srl_eeprom_model_inst.mem[5] = 16'h4321;
        srl_eeprom_model_inst.mem[6] = 16'hffff;  // Terminator
        srl_eeprom_model_inst.mem[7] = 16'h87e5;  // Must never be reached
        srl_eeprom_model_inst.mem[8] = 16'hdead;
        do_reset(1'b0, 1'b0);
        wait_done();
        check_reads(7);
        check(26'(wr_q.size()), 26'ha);
        for (int i = 0; i < 6; i++) check(wr_q[i], {5'h08 + 5'(i), 5'h05, 16'ha5c3});
        for (int i = 0; i < 3; i++) check(wr_q[6 + i], {5'(2 * i), 5'h10, 16'h0f1e});
        check(wr_q[9], {5'h0f, 5'h02, 16'h4321});
    endtask

    // Small part: six address bits, slow accept from the register side
    task automatic test_small_part();
        ack_delay = 3;
        srl_eeprom_model_inst.mem[0] = 16'h0043;  // PHY port 1, register 3
        srl_eeprom_model_inst.mem[1] = 16'hbeef;
        srl_eeprom_model_inst.mem[2] = 16'hffff;  // Terminator
        do_reset(1'b1, 1'b0);
        wait_done();
        check_reads(3);
        check(26'(wr_q.size()), 26'h1);
        check(wr_q[0], {5'h01, 5'h03, 16'hbeef});
    endtask

    // Small part with no terminator: loader stops after the last word by itself
    task automatic test_no_end();
        for (int i = 0; i < 64; i++) srl_eeprom_model_inst.mem[i] = 16'h8000;  // Empty vector
        do_reset(1'b1, 1'b0);
        wait_done();
        check_reads(64);
        check(26'(wr_q.size()), 26'h0);
    endtask

    // Standalone mode: no fetch, no writes, no done flag
    task automatic test_standalone();
        do_reset(1'b0, 1'b1);
        repeat (3000) @(negedge CLOCK_I);
        check(26'(srl_eeprom_model_inst.rd_addr.size()), 26'h0);
        check(26'(wr_q.size()), 26'h0);
        check(26'({CONFIG_LOAD_DONE_FLAG_O, LOADER_BUSY_O}), 26'h0);
    endtask

    // Main sequence
    initial begin
        NRST_I = 1'b0;
        STANDALONE_MODE_I = 1'b0;
        EEPROM_SIZE_STRAP_PIN_I = 1'b0;
        MGMT_WR_ACK_I = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        ack_delay = 0;
        ack_cnt = 0;
        ack_wait = 1'b0;
        repeat (20) @(negedge CLOCK_I);
        test_full_list();
        test_small_part();
        test_no_end();
        test_standalone();
        give_verdict();
    end
endmodule

bind srl_loader_top srl_loader_checker srl_loader_checker_inst (.CLOCK_I(CLOCK_I),
    .NRST_I(NRST_I), .EE_CS_O(EE_CS_O), .EE_SK_O(EE_SK_O), .EE_DI_O(EE_DI_O),
    .MGMT_WR_REQ_O(MGMT_WR_REQ_O), .MGMT_DEV_O(MGMT_DEV_O), .MGMT_REG_O(MGMT_REG_O),
    .MGMT_DATA_O(MGMT_DATA_O), .MGMT_WR_ACK_I(MGMT_WR_ACK_I),
    .CONFIG_LOAD_DONE_FLAG_O(CONFIG_LOAD_DONE_FLAG_O), .LOADER_BUSY_O(LOADER_BUSY_O));
`default_nettype wire
